// File: hdl/crcg_pkg.sv
// Constants shared by the CRC generator/checker design files.
// Assumes a byte-wide register port clocked by the peripheral clock.
package crcg_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [2:0] ADDR_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h1;
	localparam logic [2:0] ADDR_BYTE_INPUT = 3'h3;
	localparam logic [2:0] ADDR_CHECKSUM_LO = 3'h4;
	localparam logic [2:0] ADDR_CHECKSUM_ONE = 3'h5;
	localparam logic [2:0] ADDR_CHECKSUM_TWO = 3'h6;
	localparam logic [2:0] ADDR_CHECKSUM_HI = 3'h7;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTL_PRESET_HI = 7;
	localparam int CTL_PRESET_LO = 6;
	localparam int CTL_WIDE = 5;
	localparam int CTL_SRC_HI = 3;
	localparam int STS_ZERO = 1;
	localparam int STS_BUSY = 0;

	// ****************************************
	// Encodings and values
	// ****************************************
	localparam logic [1:0] PRESET_NONE = 2'h0;
	localparam logic [1:0] PRESET_ZEROS = 2'h2;
	localparam logic [1:0] PRESET_ONES = 2'h3;

	typedef enum logic [3:0] {
		SRC_DISABLED = 4'h0,
		SRC_REGISTER = 4'h1,
		SRC_FLASH = 4'h2,
		SRC_DMA_FIRST = 4'h4,
		SRC_DMA_SECOND = 4'h5
	} crcg_src_t;

	localparam logic [31:0] POLY16 = 32'h00001021;
	localparam logic [31:0] POLY32 = 32'h04c11db7;
	localparam logic [31:0] CHECKSUM_RESET = 32'h00000000;
	localparam logic [31:0] CHECKSUM_ONES = 32'hffffffff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage : crcg_pkg

// File: hdl/crcg_byte_step.sv
// One-byte CRC step, MSB first, for a 16- or 32-bit register.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
module crcg_byte_step (
	input wire logic [31:0] crcIn,
	input wire logic [7:0] crc_byte_input,
	input wire logic wide,
	output logic [31:0] crcOut
);
	logic [31:0] stage [0:8];
	assign stage[0] = crcIn;
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			logic fb;
			// Feedback tap sits at bit 15 or bit 31 depending on width [R1]
			assign fb = (wide ? stage[i][31] : stage[i][15]) ^ crc_byte_input[7 - i];
			assign stage[i + 1] = wide ?
				({stage[i][30:0], 1'b0} ^ (fb ? crcg_pkg::POLY32 : 32'h00000000)) :
				({16'h0000, stage[i][14:0], 1'b0} ^ (fb ? crcg_pkg::POLY16 : 32'h00000000));
		end
	endgenerate
	assign crcOut = stage[8];
endmodule : crcg_byte_step

// File: hdl/crcg_readout.sv
// Checksum read view: raw, zero for flash while busy, or reversed and complemented for CRC-32 when not busy.
// Assumes the caller registers the selected byte.
`timescale 1ns/1ps
module crcg_readout (
	input wire logic [31:0] crcVal,
	input wire logic wide,
	input wire logic busy,
	input wire logic flashSrc,
	output logic [31:0] viewOut
);
	logic [31:0] reflected;
	genvar i;
	generate
		for (i = 0; i < 32; i++) begin : g_rev
			assign reflected[i] = ~crcVal[31 - i];
		end
	endgenerate
	always_comb begin
		if (flashSrc && busy) begin
			viewOut = crcg_pkg::CHECKSUM_RESET; // [R17]
		end else if (wide && !busy) begin
			viewOut = reflected; // [R18]
		end else begin
			viewOut = crcVal; // [R19]
		end
	end
endmodule : crcg_readout

// File: hdl/crcg_top.sv
// CRC generator/checker with register port, two DMA taps and a flash tap.
// Assumes byte-wide register strobes synchronous to clk; strobes are one-cycle pulses.
//
// Overview of operation
// [R1] CRC-16 uses polynomial 0x1021, CRC-32 uses 0x04C11DB7.
// [R2] CRC-16 unless wide select set; select frozen while busy.
// [R3] Flash source always computes CRC-32.
// [R4] One CRC update per byte from the selected source.
// [R5] Preset field reads zero; 10 zeros, 11 ones, 00 and 01 nothing.
// [R6] Preset lands one cycle after preset upper bit written one.
// [R7] Source codes: 0 off, 1 register, 2 flash, 4 DMA0, 5 DMA1.
// [R8] Selected source locked until completion or preset.
// [R9] Zero flag set on zero checksum at completion; cleared on new source.
// [R10] Busy reads one from source selection while source uses engine.
// [R11] Register source: software writes one to busy to finish.
// [R12] DMA source: busy clears on channel completion or abort.
// [R13] DMA source: every channel byte folded in with no other trigger.
// [R14] Flash source: busy clears when controller finishes range.
// [R15] Updated checksum one cycle after each byte input write.
// [R16] Checksum byte writes accepted only while source is disabled.
// [R17] Flash source: checksum reads zero while busy.
// [R18] CRC-32 and not busy: reads bit-reversed and complemented.
// [R19] CRC-16 or busy: reads raw register contents.
// [R20] Four checksum bytes, least significant first; upper two CRC-32 only.
// [R21] Checksum is all zeros after system reset.
// [R22] Memory controller sets range and starts flash CRC itself.
// [R23] Reserved source codes behave as disabled; code still refuses checksum byte writes.
`timescale 1ns/1ps
module crcg_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic dmaFirstValid,
	input wire logic [7:0] dmaFirstData,
	input wire logic dmaFirstDone,
	input wire logic dmaSecondValid,
	input wire logic [7:0] dmaSecondData,
	input wire logic dmaSecondDone,
	input wire logic flashValid,
	input wire logic [7:0] flashData,
	input wire logic flashDone,
	output logic busyOut,
	output logic zeroOut
);
	// ****************************************
	// State
	// ****************************************
	logic [31:0] crc_r;
	logic [31:0] crc_nxt;
	logic wide_r;
	logic [3:0] source_r;
	logic busy_r;
	logic zero_r;
	logic [1:0] preset_r;
	logic [7:0] rdata_r;
	logic wrCtl;
	logic wrSts;
	logic wrByte;
	logic srcReg;
	logic srcFlash;
	logic srcDma1;
	logic srcDma2;
	logic srcValid;
	logic effWide;
	logic byteValid;
	logic [7:0] byteData;
	logic finish;
	logic [31:0] stepOut;
	logic [31:0] viewVal;
	logic [3:0] newSrc;
	logic newSrcValid;

	assign wrCtl = regWrite && (regAddr == crcg_pkg::ADDR_CONTROL);
	assign wrSts = regWrite && (regAddr == crcg_pkg::ADDR_STATUS);
	assign wrByte = regWrite && (regAddr == crcg_pkg::ADDR_BYTE_INPUT);

	// ****************************************
	// Source decode
	// ****************************************
	assign srcReg = source_r == crcg_pkg::SRC_REGISTER; // [R7]
	assign srcFlash = source_r == crcg_pkg::SRC_FLASH;
	assign srcDma1 = source_r == crcg_pkg::SRC_DMA_FIRST;
	assign srcDma2 = source_r == crcg_pkg::SRC_DMA_SECOND;
	// Reserved codes are not engine users [R23]
	assign srcValid = srcReg || srcFlash || srcDma1 || srcDma2;
	assign newSrc = regWdata[crcg_pkg::CTL_SRC_HI:0];
	assign newSrcValid = newSrc == crcg_pkg::SRC_REGISTER || newSrc == crcg_pkg::SRC_FLASH ||
		newSrc == crcg_pkg::SRC_DMA_FIRST || newSrc == crcg_pkg::SRC_DMA_SECOND;
	assign effWide = wide_r || srcFlash; // [R3]

	// ****************************************
	// Input mux: one byte per cycle at most
	// ****************************************
	always_comb begin
		byteValid = 1'b0;
		byteData = crcg_pkg::BYTE_ZERO;
		if (busy_r) begin
			if (srcReg) begin
				byteValid = wrByte; // [R15]
				byteData = regWdata;
			end else if (srcDma1) begin
				byteValid = dmaFirstValid; // [R13]
				byteData = dmaFirstData;
			end else if (srcDma2) begin
				byteValid = dmaSecondValid; // [R13]
				byteData = dmaSecondData;
			end else if (srcFlash) begin
				byteValid = flashValid;
				byteData = flashData;
			end
		end
	end

	// Completion from whichever source owns the engine
	always_comb begin
		finish = 1'b0;
		if (busy_r) begin
			if (srcReg) begin
				finish = wrSts && regWdata[crcg_pkg::STS_BUSY]; // [R11]
			end else if (srcDma1) begin
				finish = dmaFirstDone; // [R12]
			end else if (srcDma2) begin
				finish = dmaSecondDone; // [R12]
			end else if (srcFlash) begin
				finish = flashDone; // [R14] [R22]
			end
		end
	end

	crcg_byte_step u_step (
		.crcIn(crc_r),
		.crc_byte_input(byteData),
		.wide(effWide),
		.crcOut(stepOut)
	);

	// ****************************************
	// Checksum register
	// ****************************************
	always_comb begin
		crc_nxt = crc_r;
		if (preset_r == crcg_pkg::PRESET_ZEROS) begin
			crc_nxt = crcg_pkg::CHECKSUM_RESET; // [R6]
		end else if (preset_r == crcg_pkg::PRESET_ONES) begin
			crc_nxt = crcg_pkg::CHECKSUM_ONES; // [R6]
		end else if (byteValid) begin
			crc_nxt = stepOut; // [R4]
		end else if (regWrite && source_r == crcg_pkg::SRC_DISABLED) begin
			// Direct loading only while disabled [R16]
			case (regAddr)
				crcg_pkg::ADDR_CHECKSUM_LO: crc_nxt[7:0] = regWdata;
				crcg_pkg::ADDR_CHECKSUM_ONE: crc_nxt[15:8] = regWdata;
				crcg_pkg::ADDR_CHECKSUM_TWO: crc_nxt[23:16] = regWdata;
				crcg_pkg::ADDR_CHECKSUM_HI: crc_nxt[31:24] = regWdata;
				default: crc_nxt = crc_r;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			crc_r <= crcg_pkg::CHECKSUM_RESET; // [R21]
		end else begin
			crc_r <= crc_nxt;
		end
	end

	// Preset command is held one cycle so it lands a cycle after the write
	always_ff @(posedge clk) begin
		if (rst) begin
			preset_r <= crcg_pkg::PRESET_NONE;
		end else if (wrCtl && regWdata[crcg_pkg::CTL_PRESET_HI]) begin
			preset_r <= regWdata[crcg_pkg::CTL_PRESET_HI:crcg_pkg::CTL_PRESET_LO]; // [R5]
		end else begin
			preset_r <= crcg_pkg::PRESET_NONE;
		end
	end

	// ****************************************
	// Control: width, source and busy
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			wide_r <= 1'b0; // [R2]
		end else if (wrCtl && !busy_r) begin
			wide_r <= regWdata[crcg_pkg::CTL_WIDE]; // [R2]
		end
	end

	// Preset releases the lock; the same write may then pick a source
	always_ff @(posedge clk) begin
		if (rst) begin
			source_r <= crcg_pkg::SRC_DISABLED;
			busy_r <= 1'b0;
		end else if (wrCtl && (!busy_r || regWdata[crcg_pkg::CTL_PRESET_HI])) begin
			source_r <= newSrc; // [R8]
			busy_r <= newSrcValid; // [R10] [R23]
		end else if (finish) begin
			busy_r <= 1'b0;
		end
	end

	// Completion sets the flag; a new source selection clears it
	always_ff @(posedge clk) begin
		if (rst) begin
			zero_r <= 1'b0;
		end else if (finish) begin
			zero_r <= (crc_r == crcg_pkg::CHECKSUM_RESET); // [R9]
		end else if (wrCtl && (!busy_r || regWdata[crcg_pkg::CTL_PRESET_HI])) begin
			zero_r <= 1'b0; // [R9]
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	crcg_readout u_view (
		.crcVal(crc_r),
		.wide(effWide),
		.busy(busy_r),
		.flashSrc(srcFlash),
		.viewOut(viewVal)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_r <= crcg_pkg::BYTE_ZERO;
		end else if (regRead) begin
			case (regAddr)
				crcg_pkg::ADDR_CONTROL: rdata_r <= {2'b00, wide_r, 1'b0, source_r}; // [R5]
				crcg_pkg::ADDR_STATUS: rdata_r <= {6'h00, zero_r, busy_r};
				crcg_pkg::ADDR_CHECKSUM_LO: rdata_r <= viewVal[7:0]; // [R20]
				crcg_pkg::ADDR_CHECKSUM_ONE: rdata_r <= viewVal[15:8];
				crcg_pkg::ADDR_CHECKSUM_TWO: rdata_r <= viewVal[23:16];
				crcg_pkg::ADDR_CHECKSUM_HI: rdata_r <= viewVal[31:24];
				default: rdata_r <= crcg_pkg::BYTE_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			busyOut <= 1'b0;
			zeroOut <= 1'b0;
		end else begin
			busyOut <= busy_r;
			zeroOut <= zero_r;
		end
	end
	assign regRdata = rdata_r;

	// ****************************************
	// Checks
	// ****************************************
	preset_timing_a: assert property (@(posedge clk) disable iff (rst) // [R6]
		wrCtl && regWdata[7:6] == 2'b11 |-> ##2 crc_r == 32'hffffffff)
		else $error("preset ones did not land");
	preset_zero_a: assert property (@(posedge clk) disable iff (rst) // [R5]
		wrCtl && regWdata[7:6] == 2'b10 |-> ##2 crc_r == 32'h00000000)
		else $error("preset zeros did not land");
	width_lock_a: assert property (@(posedge clk) disable iff (rst) // [R2]
		busy_r && $past(busy_r) |-> $stable(wide_r))
		else $error("width changed while busy");
	source_lock_a: assert property (@(posedge clk) disable iff (rst) // [R8]
		busy_r && !(wrCtl && regWdata[7]) |=> $stable(source_r))
		else $error("source changed while locked");
	byte_update_a: assert property (@(posedge clk) disable iff (rst) // [R15]
		busy_r && srcReg && wrByte && preset_r == 2'b00 |=> crc_r == $past(stepOut))
		else $error("byte not folded next cycle");
	reg_finish_a: assert property (@(posedge clk) disable iff (rst) // [R11]
		busy_r && srcReg && wrSts && regWdata[0] && !wrCtl |=> !busy_r)
		else $error("busy not cleared by software");
	dma_finish_a: assert property (@(posedge clk) disable iff (rst) // [R12]
		busy_r && srcDma1 && dmaFirstDone && !wrCtl |=> !busy_r)
		else $error("busy not cleared on dma done");
	reserved_idle_a: assert property (@(posedge clk) disable iff (rst) // [R23]
		!srcValid |-> !busy_r)
		else $error("busy with reserved source");
	locked_write_a: assert property (@(posedge clk) disable iff (rst) // [R16]
		source_r != 4'h0 && !byteValid && preset_r == 2'b00 |=> $stable(crc_r))
		else $error("checksum changed while locked");
	zero_flag_a: assert property (@(posedge clk) disable iff (rst) // [R9]
		finish |=> zero_r == ($past(crc_r) == 32'h0))
		else $error("zero flag wrong at completion");

	// ****************************************
	// Checks: engine and flags
	// ****************************************
	// No disable here: this one watches what reset itself leaves behind
	reset_state_a: assert property (@(posedge clk) // [R21]
		rst |=> crc_r == crcg_pkg::CHECKSUM_RESET && !busy_r && !zero_r)
		else $error("state not cleared by reset");
	dma2_finish_a: assert property (@(posedge clk) disable iff (rst) // [R12]
		busy_r && srcDma2 && dmaSecondDone && !wrCtl |=> !busy_r)
		else $error("busy not cleared on second dma done");
	flash_finish_a: assert property (@(posedge clk) disable iff (rst) // [R14]
		busy_r && srcFlash && flashDone && !wrCtl |=> !busy_r)
		else $error("busy not cleared on flash done");
	dma_fold_a: assert property (@(posedge clk) disable iff (rst) // [R13]
		busy_r && srcDma1 && dmaFirstValid && preset_r == crcg_pkg::PRESET_NONE
			|=> crc_r == $past(stepOut))
		else $error("first dma byte not folded");
	dma2_fold_a: assert property (@(posedge clk) disable iff (rst) // [R13]
		busy_r && srcDma2 && dmaSecondValid && preset_r == crcg_pkg::PRESET_NONE
			|=> crc_r == $past(stepOut))
		else $error("second dma byte not folded");
	flash_fold_a: assert property (@(posedge clk) disable iff (rst) // [R4]
		busy_r && srcFlash && flashValid && preset_r == crcg_pkg::PRESET_NONE
			|=> crc_r == $past(stepOut))
		else $error("flash byte not folded");
	idle_hold_a: assert property (@(posedge clk) disable iff (rst) // [R4]
		busy_r && !byteValid && preset_r == crcg_pkg::PRESET_NONE |=> $stable(crc_r))
		else $error("checksum moved without a byte");
	reserved_hold_a: assert property (@(posedge clk) disable iff (rst) // [R23]
		source_r != crcg_pkg::SRC_DISABLED && !srcValid &&
			preset_r == crcg_pkg::PRESET_NONE |=> $stable(crc_r))
		else $error("reserved source changed checksum");
	busy_select_a: assert property (@(posedge clk) disable iff (rst) // [R10]
		wrCtl && !busy_r && newSrcValid |=> busy_r)
		else $error("busy not set on source select");
	zero_clear_a: assert property (@(posedge clk) disable iff (rst) // [R9]
		wrCtl && !busy_r |=> !zero_r)
		else $error("zero flag kept on new source");
	width_hold_a: assert property (@(posedge clk) disable iff (rst) // [R2]
		busy_r && wrCtl |=> $stable(wide_r))
		else $error("width taken while busy");
	direct_load_a: assert property (@(posedge clk) disable iff (rst) // [R16]
		regWrite && regAddr == crcg_pkg::ADDR_CHECKSUM_LO && source_r == crcg_pkg::SRC_DISABLED &&
			preset_r == crcg_pkg::PRESET_NONE |=> crc_r[7:0] == $past(regWdata))
		else $error("checksum byte not loaded while disabled");

	// ****************************************
	// Checks: read path and outputs
	// ****************************************
	flags_out_a: assert property (@(posedge clk) disable iff (rst) // [R10]
		busyOut == $past(busy_r) && zeroOut == $past(zero_r))
		else $error("flag outputs do not follow flags");
	status_read_a: assert property (@(posedge clk) disable iff (rst) // [R10]
		regRead && regAddr == crcg_pkg::ADDR_STATUS |=>
			rdata_r == {6'h00, $past(zero_r), $past(busy_r)})
		else $error("status read wrong");
	control_read_a: assert property (@(posedge clk) disable iff (rst) // [R5]
		regRead && regAddr == crcg_pkg::ADDR_CONTROL |=>
			rdata_r == {2'b00, $past(wide_r), 1'b0, $past(source_r)})
		else $error("control read wrong");
	flash_hidden_a: assert property (@(posedge clk) disable iff (rst) // [R17]
		regRead && regAddr == crcg_pkg::ADDR_CHECKSUM_LO && srcFlash && busy_r |=>
			rdata_r == crcg_pkg::BYTE_ZERO)
		else $error("flash checksum visible while busy");
endmodule : crcg_top

// File: tb/crcg_stream_src.sv
// Byte stream source standing in for a DMA channel or the flash controller.
// Assumes the bench calls drive() once per cycle; outputs change after rising edges.
`timescale 1ns/1ps
module crcg_stream_src (
	input wire logic clk,
	output logic valid,
	output logic [7:0] data,
	output logic done
);
	initial begin
		valid = 1'b0;
		data = 8'ha5;
		done = 1'b0;
	end
	// Released data is inverted so a stale byte never holds for two cycles in a row
	task drive(input logic v, input logic [7:0] b, input logic dn);
		@(posedge clk);
		valid <= v;
		data <= v ? b : ~data;
		done <= dn;
	endtask : drive
endmodule : crcg_stream_src

// File: tb/crcg_top_test.sv
// Self-checking bench for the CRC generator/checker.
// Assumes three stream source models on the DMA and flash taps.
`timescale 1ns/1ps
module crcg_top_test;
	logic clk, rst, regWrite, regRead, busyOut, zeroOut;
	logic [2:0] regAddr;
	logic [7:0] regWdata, regRdata, b;
	logic v0, v1, v2, dn0, dn1, dn2;
	logic [7:0] d0, d1, d2;
	logic [31:0] crc, got;
	int miscompares, check_count, cycles;
	crcg_top crcg_top_inst (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
		.regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
		.dmaFirstValid(v0), .dmaFirstData(d0), .dmaFirstDone(dn0),
		.dmaSecondValid(v1), .dmaSecondData(d1), .dmaSecondDone(dn1),
		.flashValid(v2), .flashData(d2), .flashDone(dn2),
		.busyOut(busyOut), .zeroOut(zeroOut));
	crcg_stream_src dmaFirstSrc (.clk(clk), .valid(v0), .data(d0), .done(dn0));
	crcg_stream_src dmaSecondSrc (.clk(clk), .valid(v1), .data(d1), .done(dn1));
	crcg_stream_src flashSrc (.clk(clk), .valid(v2), .data(d2), .done(dn2));
	// ****************
	// Models and tasks
	// ****************
	function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d,
		input logic w);
		logic fb;
		for (int i = 7; i >= 0; i--) begin
			fb = (w ? c[31] : c[15]) ^ d[i];
			c = c << 1;
			if (fb) c = c ^ (w ? 32'h04c11db7 : 32'h00001021);
		end
		return w ? c : {16'h0000, c[15:0]};
	endfunction : step
	function automatic logic [31:0] view(input logic [31:0] c);
		logic [31:0] r;
		for (int i = 0; i < 32; i++) r[i] = c[31 - i];
		return ~r;
	endfunction : view
	task close_out();
		$display("comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out
	task chk8(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk8
	task chk32(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk32
	task bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= w;
		regRead <= r;
		regAddr <= a;
		regWdata <= d;
	endtask : bus
	// Strobe stays high across back-to-back calls; any read or tick drops it
	task wr(input logic [2:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr
	task rd(input logic [2:0] a, output logic [7:0] v);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		@(posedge clk);
		#1 v = regRdata;
	endtask : rd
	task rdchk(input logic [2:0] a, input logic [7:0] e);
		rd(a, b);
		chk8(b, e);
	endtask : rdchk
	// Status register and the registered flag pins must agree
	task stchk(input logic [7:0] e);
		rdchk(crcg_pkg::ADDR_STATUS, e);
		chk8({6'h00, zeroOut, busyOut}, e);
	endtask : stchk
	task rsum(input int n, output logic [31:0] v);
		v = 32'h00000000;
		for (int i = 0; i < n; i++) begin
			rd(3'(crcg_pkg::ADDR_CHECKSUM_LO + i), b);
			v[8*i +: 8] = b;
		end
	endtask : rsum
	task feed(input logic [7:0] d, input logic w);
		wr(crcg_pkg::ADDR_BYTE_INPUT, d);
		crc = step(crc, d, w);
	endtask : feed
	// Unselected taps stream the inverse byte at the same time, which must be ignored
	task tick(input int sel, input logic v, input logic [7:0] x, input logic dn);
		fork
			bus(1'b0, 1'b0, 3'h0, 8'h00);
			dmaFirstSrc.drive(v, sel == 0 ? x : ~x, dn && sel == 0);
			dmaSecondSrc.drive(v, sel == 1 ? x : ~x, dn && sel == 1);
			flashSrc.drive(v, sel == 2 ? x : ~x, dn && sel == 2);
		join
	endtask : tick
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			close_out();
		end
	end
	// ****************
	// Tests
	// ****************
	initial begin
		rst = 1'b1;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 3'h0;
		regWdata = 8'h00;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rdchk(crcg_pkg::ADDR_CONTROL, 8'h00);
		stchk(8'h00);
		rsum(4, got);
		chk32(got, 32'h00000000);
		rdchk(3'h2, 8'h00);
		wr(crcg_pkg::ADDR_CONTROL, 8'h81);
		crc = 32'h00000000;
		stchk(8'h01);
		rdchk(crcg_pkg::ADDR_CONTROL, 8'h01);
		feed(8'h31, 1'b0);
		feed(8'h32, 1'b0);
		feed(8'h33, 1'b0);
		wr(crcg_pkg::ADDR_CHECKSUM_LO, 8'h5a);
		wr(crcg_pkg::ADDR_CONTROL, 8'h22);
		rdchk(crcg_pkg::ADDR_CONTROL, 8'h01);
		rsum(2, got);
		chk32(got, crc);
		// Appending the remainder must leave zero
		got = crc;
		feed(got[15:8], 1'b0);
		feed(got[7:0], 1'b0);
		wr(crcg_pkg::ADDR_STATUS, 8'h01);
		stchk(8'h02);
		wr(crcg_pkg::ADDR_CONTROL, 8'he1);
		crc = 32'hffffffff;
		stchk(8'h01);
		rsum(4, got);
		chk32(got, crc);
		feed(8'ha5, 1'b1);
		feed(8'h00, 1'b1);
		feed(8'hff, 1'b1);
		wr(crcg_pkg::ADDR_STATUS, 8'h01);
		rsum(4, got);
		chk32(got, view(crc));
		stchk({6'h00, crc == 32'h0, 1'b0});
		for (int ch = 0; ch < 2; ch++) begin
			wr(crcg_pkg::ADDR_CONTROL, 8'(8'h84 + ch));
			crc = 32'h00000000;
			// Preset lands on the next edge and beats any byte there
			tick(ch, 1'b0, 8'h00, 1'b0);
			for (int k = 0; k < 4; k++) begin
				tick(ch, 1'b1, 8'(8'h10 + 8'h33 * k), 1'b0);
				crc = step(crc, 8'(8'h10 + 8'h33 * k), 1'b0);
			end
			tick(ch, 1'b0, 8'h00, 1'b1);
			tick(ch, 1'b0, 8'h00, 1'b0);
			stchk(8'h00);
			rsum(2, got);
			chk32(got, crc);
		end
		wr(crcg_pkg::ADDR_CONTROL, 8'h82);
		crc = 32'h00000000;
		tick(2, 1'b0, 8'h00, 1'b0);
		for (int k = 0; k < 5; k++) begin
			tick(2, 1'b1, 8'(8'hc1 + k), 1'b0);
			crc = step(crc, 8'(8'hc1 + k), 1'b1);
		end
		tick(2, 1'b0, 8'h00, 1'b0);
		rsum(4, got);
		chk32(got, 32'h00000000);
		tick(2, 1'b0, 8'h00, 1'b1);
		tick(2, 1'b0, 8'h00, 1'b0);
		rsum(4, got);
		chk32(got, view(crc));
		wr(crcg_pkg::ADDR_CONTROL, 8'h83);
		stchk(8'h00);
		wr(crcg_pkg::ADDR_CONTROL, 8'h00);
		wr(crcg_pkg::ADDR_CHECKSUM_LO, 8'h3c);
		wr(crcg_pkg::ADDR_CHECKSUM_ONE, 8'hc3);
		rsum(2, got);
		chk32(got, 32'h0000c33c);
		close_out();
	end
endmodule : crcg_top_test
